//--- design/dgn_pkg.sv
package dgn_pkg;

	// ---------------------------------------------------------------
	// Register byte addresses
	// ---------------------------------------------------------------
	localparam logic [11:0] ADDR_GAIN = 12'h15B;
	localparam logic [11:0] ADDR_SYNC_CTRL = 12'h160;
	localparam logic [11:0] ADDR_FMT = 12'h162;
	localparam logic [11:0] ADDR_ROUTE = 12'h163;
	localparam logic [11:0] ADDR_MODE = 12'h164;
	localparam logic [11:0] ADDR_UPDATE = 12'h165;
	localparam logic [11:0] ADDR_ASSIGN = 12'h166;
	localparam logic [11:0] ADDR_DEC_LO = 12'h167;
	localparam logic [11:0] ADDR_DEC_HI = 12'h168;
	localparam logic [11:0] ADDR_BAND = 12'h169;
	localparam logic [11:0] ADDR_NCO_FIRST = 12'h200;
	localparam logic [11:0] ADDR_NCO_LAST = 12'h2DF;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_ROUTE = 8'h03;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int FMT_COMPLEX_BIT = 2;
	localparam int FMT_WIDE_BIT = 1;
	localparam int MODE_COHERENT_BIT = 0;
	localparam int MODE_NEGATE_BIT = 1;
	localparam int UPD_LOAD_BIT = 0;
	localparam int SYNC_SYSREF_BIT = 2;
	localparam int BAND_PER_DDC_BIT = 7;
	localparam int BAND_LSB = 4;
	localparam int DEC_W = 4;
	localparam int SEL_W = 2;

	// ---------------------------------------------------------------
	// Band codes and decimation limits (code k means divide by 2**k)
	// ---------------------------------------------------------------
	localparam logic [1:0] BAND_SINGLE = 2'h0;
	localparam logic [1:0] BAND_QUAD = 2'h1;
	localparam logic [3:0] DEC_OFF = 4'h0;
	localparam logic [3:0] MIN_SINGLE = 4'h1;
	localparam logic [3:0] MIN_DUAL = 4'h2;
	localparam logic [3:0] MIN_QUAD = 4'h3;
	localparam logic [3:0] MAX_SINGLE = 4'hC;
	localparam logic [3:0] MAX_DUAL = 4'hF;
	localparam logic [3:0] MAX_QUAD = 4'hC;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NUM_DDC = 4;
	localparam int NUM_FREQ = 4;
	localparam int FREQ_BYTES = 6;
	localparam int NCO_BYTES = 224;
	localparam int ADC_W = 14;
	localparam int OUT_W = 16;
	localparam int PHASE_W = 48;
	localparam int ACC_W = 40;
	localparam int MIX_W = 22;
	localparam int CNT_W = 15;

	// ---------------------------------------------------------------
	// Datapath constants
	// ---------------------------------------------------------------
	localparam logic signed [9:0] GAIN_UNITY = 10'h080;
	localparam int GAIN_SHIFT = 7;
	localparam logic signed [23:0] SAT_HI = 24'h001FFF;
	localparam logic signed [23:0] SAT_LO = 24'hFFE000;
	localparam logic [4:0] OUT_ALIGN = 5'h05;
	localparam logic [3:0] QUARTER_TURN = 4'h4;
	localparam logic [7:0] COS_LUT [16] = '{
		8'h7F, 8'h75, 8'h5A, 8'h31, 8'h00, 8'hCF, 8'hA6, 8'h8B,
		8'h81, 8'h8B, 8'hA6, 8'hCF, 8'h00, 8'h31, 8'h5A, 8'h75};

	// ---------------------------------------------------------------
	// Serial port framing
	// ---------------------------------------------------------------
	localparam logic [4:0] SPI_LAST_BIT = 5'h17;
	localparam logic [4:0] SPI_DATA_START = 5'h10;
	localparam int SPI_RW_WR = 22;
	localparam int SPI_RW_RD = 15;

endpackage : dgn_pkg

//--- design/dgn_core.sv
`timescale 1ns/1ps
`default_nettype none
module dgn_core (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [13:0] adc_data_in,
	input wire logic sysref_in,
	input wire logic spi_sclk_in,
	input wire logic spi_sen_n_in,
	input wire logic spi_sdi_in,
	output logic spi_sdo_out,
	output logic spi_sdo_oe_out,
	output logic [13:0] bypass_data_out,
	output logic [63:0] ddc_i_out,
	output logic [63:0] ddc_q_out,
	output logic frame_valid_out,
	output logic complex_mode_out,
	output logic wide_output_out
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic dgn_nco_hit(input logic [11:0] addr);
		return addr >= dgn_pkg::ADDR_NCO_FIRST &&
			addr <= dgn_pkg::ADDR_NCO_LAST;
	endfunction : dgn_nco_hit

	function automatic logic [3:0] dgn_clamp(input logic [3:0] code,
		input logic [1:0] band);
		logic [3:0] lo;
		logic [3:0] hi;
		lo = dgn_pkg::MIN_DUAL;
		hi = dgn_pkg::MAX_DUAL;
		if (band == dgn_pkg::BAND_SINGLE) begin
			lo = dgn_pkg::MIN_SINGLE;
			hi = dgn_pkg::MAX_SINGLE;
		end else if (band == dgn_pkg::BAND_QUAD) begin
			lo = dgn_pkg::MIN_QUAD;
			hi = dgn_pkg::MAX_QUAD;
		end
		if (code < lo)
			return lo;
		else if (code > hi)
			return hi;
		return code;
	endfunction : dgn_clamp

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic [3:0] pin_s3_q;
	assign pin_raw = {sysref_in, spi_sclk_in, spi_sen_n_in, spi_sdi_in};

	// The serial enable idles high, so its stages start high; otherwise
	// the port would see a false select for two cycles after reset.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pin_s1_q <= 4'h2;
			pin_s2_q <= 4'h2;
			pin_s3_q <= 4'h2;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic sen_active;
	logic sysref_pin_rise;
	assign sclk_rise = pin_s2_q[2] & ~pin_s3_q[2];
	assign sclk_fall = ~pin_s2_q[2] & pin_s3_q[2];
	assign sen_active = ~pin_s2_q[1];
	assign sysref_pin_rise = pin_s2_q[3] & ~pin_s3_q[3];

	// ---------------------------------------------------------------
	// Serial register port
	// ---------------------------------------------------------------
	// The port samples a resynchronised clock, so its serial clock must
	// stay below a sixth of the system clock.
	logic [22:0] spi_shift_q;
	logic [4:0] spi_cnt_q;
	logic [7:0] rd_shift_q;
	logic [7:0] rd_data;
	logic wr_en_q;
	logic [11:0] wr_addr_q;
	logic [7:0] wr_data_q;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			spi_shift_q <= 23'h000000;
			spi_cnt_q <= 5'h00;
			rd_shift_q <= 8'h00;
			spi_sdo_oe_out <= 1'b0;
			wr_en_q <= 1'b0;
			wr_addr_q <= 12'h000;
			wr_data_q <= 8'h00;
		end else begin
			wr_en_q <= 1'b0;
			if (!sen_active) begin
				spi_cnt_q <= 5'h00;
				spi_sdo_oe_out <= 1'b0;
			end else if (sclk_rise) begin
				spi_shift_q <= {spi_shift_q[21:0], pin_s2_q[0]};
				spi_cnt_q <= spi_cnt_q + 5'h01;
				if (spi_cnt_q == dgn_pkg::SPI_LAST_BIT &&
					!spi_shift_q[dgn_pkg::SPI_RW_WR]) begin
					wr_en_q <= 1'b1;
					wr_addr_q <= spi_shift_q[18:7];
					wr_data_q <= {spi_shift_q[6:0], pin_s2_q[0]};
				end
			end else if (sclk_fall) begin
				if (spi_cnt_q == dgn_pkg::SPI_DATA_START &&
					spi_shift_q[dgn_pkg::SPI_RW_RD]) begin
					rd_shift_q <= rd_data;
					spi_sdo_oe_out <= 1'b1;
				end else if (spi_cnt_q > dgn_pkg::SPI_DATA_START) begin
					rd_shift_q <= {rd_shift_q[6:0], 1'b0};
				end
			end
		end
	end

	assign spi_sdo_out = rd_shift_q[7];

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	logic [7:0] gain_q;
	logic [7:0] sync_ctrl_q;
	logic [7:0] fmt_q;
	logic [7:0] route_q;
	logic [7:0] mode_q;
	logic [7:0] update_q;
	logic [7:0] assign_q;
	logic [7:0] dec_lo_q;
	logic [7:0] dec_hi_q;
	logic [7:0] band_q;
	logic [7:0] nco_mem [dgn_pkg::NCO_BYTES];

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			gain_q <= dgn_pkg::RST_ZERO;
			sync_ctrl_q <= dgn_pkg::RST_ZERO;
			fmt_q <= dgn_pkg::RST_ZERO;
			route_q <= dgn_pkg::RST_ROUTE;
			mode_q <= dgn_pkg::RST_ZERO;
			update_q <= dgn_pkg::RST_ZERO;
			assign_q <= dgn_pkg::RST_ZERO;
			dec_lo_q <= dgn_pkg::RST_ZERO;
			dec_hi_q <= dgn_pkg::RST_ZERO;
			band_q <= dgn_pkg::RST_ZERO;
		end else if (wr_en_q) begin
			if (wr_addr_q == dgn_pkg::ADDR_GAIN)
				gain_q <= wr_data_q;
			else if (wr_addr_q == dgn_pkg::ADDR_SYNC_CTRL)
				sync_ctrl_q <= wr_data_q;
			else if (wr_addr_q == dgn_pkg::ADDR_FMT)
				fmt_q <= wr_data_q;
			else if (wr_addr_q == dgn_pkg::ADDR_ROUTE)
				route_q <= wr_data_q;
			else if (wr_addr_q == dgn_pkg::ADDR_MODE)
				mode_q <= wr_data_q;
			else if (wr_addr_q == dgn_pkg::ADDR_UPDATE)
				update_q <= wr_data_q;
			else if (wr_addr_q == dgn_pkg::ADDR_ASSIGN)
				assign_q <= wr_data_q;
			else if (wr_addr_q == dgn_pkg::ADDR_DEC_LO)
				dec_lo_q <= wr_data_q;
			else if (wr_addr_q == dgn_pkg::ADDR_DEC_HI)
				dec_hi_q <= wr_data_q;
			else if (wr_addr_q == dgn_pkg::ADDR_BAND)
				band_q <= wr_data_q;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < dgn_pkg::NCO_BYTES; i++)
				nco_mem[i] <= dgn_pkg::RST_ZERO;
		end else if (wr_en_q && dgn_nco_hit(wr_addr_q)) begin
			nco_mem[8'(wr_addr_q - dgn_pkg::ADDR_NCO_FIRST)] <= wr_data_q;
		end
	end

	always_comb begin
		logic [11:0] ra;
		ra = spi_shift_q[11:0];
		rd_data = 8'h00;
		if (ra == dgn_pkg::ADDR_GAIN)
			rd_data = gain_q;
		else if (ra == dgn_pkg::ADDR_SYNC_CTRL)
			rd_data = sync_ctrl_q;
		else if (ra == dgn_pkg::ADDR_FMT)
			rd_data = fmt_q;
		else if (ra == dgn_pkg::ADDR_ROUTE)
			rd_data = route_q;
		else if (ra == dgn_pkg::ADDR_MODE)
			rd_data = mode_q;
		else if (ra == dgn_pkg::ADDR_UPDATE)
			rd_data = update_q;
		else if (ra == dgn_pkg::ADDR_ASSIGN)
			rd_data = assign_q;
		else if (ra == dgn_pkg::ADDR_DEC_LO)
			rd_data = dec_lo_q;
		else if (ra == dgn_pkg::ADDR_DEC_HI)
			rd_data = dec_hi_q;
		else if (ra == dgn_pkg::ADDR_BAND)
			rd_data = band_q;
		else if (dgn_nco_hit(ra))
			rd_data = nco_mem[8'(ra - dgn_pkg::ADDR_NCO_FIRST)];
	end

	// ---------------------------------------------------------------
	// Update and sync events
	// ---------------------------------------------------------------
	logic update_prev_q;
	logic sync_prev_q;
	logic load_rise;
	logic sysref_evt;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			update_prev_q <= 1'b0;
			sync_prev_q <= 1'b0;
		end else begin
			update_prev_q <= update_q[dgn_pkg::UPD_LOAD_BIT];
			sync_prev_q <= sync_ctrl_q[dgn_pkg::SYNC_SYSREF_BIT];
		end
	end

	assign load_rise = update_q[dgn_pkg::UPD_LOAD_BIT] & ~update_prev_q;
	assign sysref_evt = sysref_pin_rise |
		(sync_ctrl_q[dgn_pkg::SYNC_SYSREF_BIT] & ~sync_prev_q);

	// ---------------------------------------------------------------
	// Digital gain
	// ---------------------------------------------------------------
	logic signed [13:0] gain_x_q;
	logic signed [9:0] gain_mult;
	logic signed [23:0] gain_prod;
	logic signed [23:0] gain_scaled;
	// factor (128 + code) / 128
	assign gain_mult = dgn_pkg::GAIN_UNITY +
		$signed({{2{gain_q[7]}}, gain_q});
	assign gain_prod = $signed(adc_data_in) * gain_mult;
	assign gain_scaled = gain_prod >>> dgn_pkg::GAIN_SHIFT;

	// Positive gain can exceed full scale, so the result saturates.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			gain_x_q <= 14'h0000;
		else if (gain_scaled > dgn_pkg::SAT_HI)
			gain_x_q <= dgn_pkg::SAT_HI[13:0];
		else if (gain_scaled < dgn_pkg::SAT_LO)
			gain_x_q <= dgn_pkg::SAT_LO[13:0];
		else
			gain_x_q <= gain_scaled[13:0];
	end

	assign bypass_data_out = gain_x_q;

	// ---------------------------------------------------------------
	// Oscillator frequencies and coherent phases
	// ---------------------------------------------------------------
	localparam int NW = dgn_pkg::NUM_DDC * dgn_pkg::NUM_FREQ;
	logic [47:0] pend_q [NW];
	logic [47:0] act_q [NW];
	logic [47:0] coh_q [NW];

	for (genvar k = 0; k < NW; k++) begin : g_word
		localparam int B = k * dgn_pkg::FREQ_BYTES;
		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				pend_q[k] <= 48'h000000000000;
				act_q[k] <= 48'h000000000000;
				coh_q[k] <= 48'h000000000000;
			end else begin
				if (load_rise)
					pend_q[k] <= {nco_mem[B + 5], nco_mem[B + 4],
						nco_mem[B + 3], nco_mem[B + 2],
						nco_mem[B + 1], nco_mem[B]};
				if (sysref_evt)
					act_q[k] <= pend_q[k];
				if (sysref_evt)
					coh_q[k] <= 48'h000000000000;
				else
					coh_q[k] <= coh_q[k] + act_q[k];
			end
		end
	end

	// ---------------------------------------------------------------
	// Down-converters
	// ---------------------------------------------------------------
	logic [1:0] band;
	logic decim_on;
	logic complex_eff;
	logic [3:0] code_eff [dgn_pkg::NUM_DDC];
	logic [3:0] ddc_active;
	logic [47:0] cont_q [dgn_pkg::NUM_DDC];
	logic [15:0] hold_i_q [dgn_pkg::NUM_DDC];
	logic [15:0] hold_q_q [dgn_pkg::NUM_DDC];

	assign band = band_q[dgn_pkg::BAND_LSB +: 2];
	assign decim_on = band_q[3:0] != dgn_pkg::DEC_OFF ||
		band_q[dgn_pkg::BAND_PER_DDC_BIT];
	assign complex_eff = fmt_q[dgn_pkg::FMT_COMPLEX_BIT] ||
		band != dgn_pkg::BAND_SINGLE;

	for (genvar d = 0; d < dgn_pkg::NUM_DDC; d++) begin : g_ddc
		logic [1:0] sel;
		logic [3:0] code_raw;
		logic [47:0] phase;
		logic signed [7:0] cos_v;
		logic signed [7:0] sin_v;
		logic signed [21:0] mix_i_q;
		logic signed [21:0] mix_q_q;
		logic signed [39:0] acc_i_q;
		logic signed [39:0] acc_q_q;
		logic signed [39:0] sum_i;
		logic signed [39:0] sum_q;
		logic [14:0] cnt_q;
		logic dump;

		assign sel = assign_q[dgn_pkg::SEL_W * d +: dgn_pkg::SEL_W];
		if (d < 2) begin : g_lo
			assign code_raw = band_q[dgn_pkg::BAND_PER_DDC_BIT] ?
				dec_lo_q[dgn_pkg::DEC_W * d +: dgn_pkg::DEC_W] :
				band_q[3:0];
		end else begin : g_hi
			assign code_raw = band_q[dgn_pkg::BAND_PER_DDC_BIT] ?
				dec_hi_q[dgn_pkg::DEC_W * (d - 2) +: dgn_pkg::DEC_W] :
				band_q[3:0];
		end
		assign code_eff[d] = dgn_clamp(code_raw, band);
		assign ddc_active[d] = route_q[d] && (d == 0 ||
			(d < 2 && band != dgn_pkg::BAND_SINGLE) ||
			band == dgn_pkg::BAND_QUAD);

		assign phase = mode_q[dgn_pkg::MODE_COHERENT_BIT] ?
			coh_q[d * dgn_pkg::NUM_FREQ + int'(sel)] : cont_q[d];
		assign cos_v = $signed(dgn_pkg::COS_LUT[phase[47:44]]);
		assign sin_v = $signed(dgn_pkg::COS_LUT[4'(phase[47:44] -
			dgn_pkg::QUARTER_TURN)]);

		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in)
				cont_q[d] <= 48'h000000000000;
			else if (sysref_evt)
				cont_q[d] <= 48'h000000000000;
			else
				cont_q[d] <= cont_q[d] +
					act_q[d * dgn_pkg::NUM_FREQ + int'(sel)];
		end

		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				mix_i_q <= 22'h000000;
				mix_q_q <= 22'h000000;
			end else begin
				mix_i_q <= gain_x_q * cos_v;
				if (mode_q[dgn_pkg::MODE_NEGATE_BIT])
					mix_q_q <= -(gain_x_q * sin_v);
				else
					mix_q_q <= gain_x_q * sin_v;
			end
		end

		// Boxcar integrate-and-dump: cheap, but far from the stop band
		// of a multi-stage half-band chain.
		assign dump = cnt_q == 15'((16'h0001 << code_eff[d]) - 16'h0001);
		assign sum_i = acc_i_q + 40'(mix_i_q);
		assign sum_q = acc_q_q + 40'(mix_q_q);

		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				cnt_q <= 15'h0000;
				acc_i_q <= 40'h0000000000;
				acc_q_q <= 40'h0000000000;
				hold_i_q[d] <= 16'h0000;
				hold_q_q[d] <= 16'h0000;
			end else if (sysref_evt || !decim_on) begin
				cnt_q <= 15'h0000;
				acc_i_q <= 40'h0000000000;
				acc_q_q <= 40'h0000000000;
			end else if (dump) begin
				cnt_q <= 15'h0000;
				acc_i_q <= 40'h0000000000;
				acc_q_q <= 40'h0000000000;
				hold_i_q[d] <= 16'(sum_i >>>
					(5'(code_eff[d]) + dgn_pkg::OUT_ALIGN));
				hold_q_q[d] <= complex_eff ? 16'(sum_q >>>
					(5'(code_eff[d]) + dgn_pkg::OUT_ALIGN)) : 16'h0000;
			end else begin
				cnt_q <= cnt_q + 15'h0001;
				acc_i_q <= sum_i;
				acc_q_q <= sum_q;
			end
		end
	end

	// ---------------------------------------------------------------
	// Output framing
	// ---------------------------------------------------------------
	logic [3:0] min_code;
	logic [14:0] frame_cnt_q;
	logic frame_tick;

	// fastest of converter 0 and the active converters sets the rate
	always_comb begin
		min_code = code_eff[0];
		for (int d = 1; d < dgn_pkg::NUM_DDC; d++)
			if (ddc_active[d] && code_eff[d] < min_code)
				min_code = code_eff[d];
	end

	assign frame_tick = decim_on &&
		frame_cnt_q == 15'((16'h0001 << min_code) - 16'h0001);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			frame_cnt_q <= 15'h0000;
		else if (sysref_evt || frame_tick || !decim_on)
			frame_cnt_q <= 15'h0000;
		else
			frame_cnt_q <= frame_cnt_q + 15'h0001;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ddc_i_out <= 64'h0000000000000000;
			ddc_q_out <= 64'h0000000000000000;
			frame_valid_out <= 1'b0;
			complex_mode_out <= 1'b0;
			wide_output_out <= 1'b0;
		end else begin
			frame_valid_out <= frame_tick;
			complex_mode_out <= complex_eff;
			wide_output_out <= fmt_q[dgn_pkg::FMT_WIDE_BIT];
			if (frame_tick) begin
				for (int d = 0; d < dgn_pkg::NUM_DDC; d++) begin
					ddc_i_out[16 * d +: 16] <= ddc_active[d] ?
						hold_i_q[d] : 16'h0000;
					ddc_q_out[16 * d +: 16] <= ddc_active[d] ?
						hold_q_q[d] : 16'h0000;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	chk_gain_unity: assert property (
		gain_q == 8'h00 |=> gain_x_q == $past(adc_data_in))
		else $error("unity gain changed the sample");
	chk_band_min: assert property (
		band != dgn_pkg::BAND_SINGLE |-> code_eff[1] >= dgn_pkg::MIN_DUAL)
		else $error("decimation below band minimum");
	chk_real_single: assert property (
		band != dgn_pkg::BAND_SINGLE |=> complex_mode_out)
		else $error("real decimation with several bands");
	chk_route_idle: assert property (
		frame_valid_out && !$past(ddc_active[3]) |->
		ddc_i_out[63:48] == 16'h0000)
		else $error("unrouted converter produced data");
	chk_phase_step: assert property (
		!sysref_evt |=> cont_q[0] == $past(cont_q[0]) +
		$past(act_q[int'(assign_q[1:0])]))
		else $error("phase did not advance by the frequency");
	chk_freq_hold: assert property (
		!sysref_evt |=> $stable(act_q[0]))
		else $error("frequency applied without sync");
	chk_sync_reset: assert property (
		sysref_evt |=> cont_q[1] == 48'h000000000000 &&
		frame_cnt_q == 15'h0000)
		else $error("sync did not reset phase and divider");
	chk_frame_space: assert property (
		frame_tick && min_code >= 4'h2 |=> !frame_tick [*3])
		else $error("frames closer than the fastest ratio");

endmodule : dgn_core
`default_nettype wire

//--- test/dgn_sink.sv
`timescale 1ns/1ps
`default_nettype none
module dgn_sink (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic frame_in,
	output int gap_out
);
	int cnt_q;
	// The receiver never stalls; it only measures the spacing of frames.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= 1;
			gap_out <= 0;
		end else if (frame_in) begin
			cnt_q <= 1;
			gap_out <= cnt_q;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule : dgn_sink
`default_nettype wire

//--- test/tb_ddc_gain_nco_decimator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ddc_gain_nco_decimator;
	logic clk = 0, rst = 1, sref = 0, sclk = 0, sen_n = 1, sdi = 0;
	logic [13:0] adc = 14'h0000;
	logic sdo, sdo_oe, frame, cplx, wide;
	logic [13:0] byp;
	logic [63:0] di, dq;
	logic [15:0] seen;
	logic [7:0] q;
	logic oe;
	logic [15:0] exp_q[$];
	int n_errors = 0, checks_done = 0, gap, cyc = 0;
	event got;
	dgn_core DUT (.clk_sys_in(clk), .rst_in(rst), .adc_data_in(adc),
		.sysref_in(sref), .spi_sclk_in(sclk), .spi_sen_n_in(sen_n),
		.spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
		.bypass_data_out(byp), .ddc_i_out(di), .ddc_q_out(dq),
		.frame_valid_out(frame), .complex_mode_out(cplx),
		.wide_output_out(wide));
	dgn_sink sink (.clk_in(clk), .rst_in(rst), .frame_in(frame),
		.gap_out(gap));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task test_done;
		if (n_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			test_done();
		end
	end
	// Scoreboard: the oldest note is compared with each result shown.
	always @(got) begin
		logic [15:0] e;
		e = exp_q.pop_front();
		checks_done++;
		if (e !== seen) begin
			n_errors++;
			$display("ERROR result exp %h got %h", e, seen);
		end
	end
	task show(input logic [15:0] e, input logic [15:0] s);
		exp_q.push_back(e);
		seen = s;
		->got;
		#1;
	endtask : show
	// One 24-bit serial frame, MSB first, sclk at clk/7.
	task xfer(input logic rd, input logic [11:0] a, input logic [7:0] d);
		logic [23:0] f;
		f = {rd, 3'h0, a, d};
		@(posedge clk) sen_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			@(posedge clk) sdi <= f[i];
			sclk <= 1'b0;
			repeat (4) @(posedge clk);
			if (i < 8) q[i] = sdo;
			if (i == 0) oe = sdo_oe;
			sclk <= 1'b1;
			repeat (2) @(posedge clk);
		end
		repeat (8) @(posedge clk);
		sen_n <= 1'b1;
		sclk <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : xfer
	task gap_is(input int e);
		repeat (3) begin
			for (int k = 0; k < 3000 && frame !== 1'b1; k++) @(negedge clk);
			@(negedge clk);
		end
		show(e[15:0], gap[15:0]);
	endtask : gap_is
	initial begin
		int x, y;
		logic [11:0] ld [6] = '{12'h165, 12'h165, 12'h165, 12'h160,
			12'h160, 12'h160};
		logic [7:0] lv [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h04, 8'h00};
		x = $urandom(32'h7230);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		xfer(1'b1, 12'h163, 8'h00);
		show(16'h0003, {8'h00, q});
		xfer(1'b1, 12'h15B, 8'h00);
		show(16'h0000, {8'h00, q});
		show(16'h0001, {15'h0000, oe});
		xfer(1'b0, 12'h15B, 8'h7F);
		for (int n = 0; n < 20; n++) begin
			x = $signed(14'($urandom));
			y = (x * 255) >>> 7;
			y = y > 8191 ? 8191 : (y < -8192 ? -8192 : y);
			@(posedge clk) adc <= 14'(x);
			@(posedge clk);
			#1;
			show({2'b00, 14'(y)}, {2'b00, byp});
		end
		x = $urandom;
		xfer(1'b0, 12'h2DF, 8'(x));
		xfer(1'b1, 12'h2DF, 8'h00);
		show({8'h00, 8'(x)}, {8'h00, q});
		xfer(1'b1, 12'h100, 8'h00);
		show(16'h0000, {8'h00, q});
		for (int k = 0; k < 6; k++) xfer(1'b0, ld[k], lv[k]);
		@(posedge clk) sref <= 1'b1;
		@(posedge clk) sref <= 1'b0;
		xfer(1'b0, 12'h169, 8'h01);
		gap_is(2);
		show(16'h0000, dq[15:0]);
		xfer(1'b0, 12'h162, 8'h06);
		xfer(1'b0, 12'h169, 8'h1A);
		gap_is(1024);
		show(16'h0000, di[47:32]);
		show(16'h0000, di[63:48]);
		show(16'h0003, {14'h0000, cplx, wide});
		test_done();
	end
endmodule : tb_ddc_gain_nco_decimator
`default_nettype wire
